// ### rsc_reset_ctrl.v
// rsc_reset_ctrl.v: reset source controller top
`timescale 1ns/100ps
`include "rsc_regs.vh"
module rsc_reset_ctrl (
   input  wire        sys_clk,                 // system clock
   input  wire        srst,                    // sync reset, high
   input  wire        system_clock_out,        // clock out edge pulse
   input  wire        rst_pin_in,              // reset pin level
   output wire        rst_pin_out,             // pin drive value
   output wire        rst_pin_oe_n,            // pin enable, low drives
   input  wire        por_req,                 // power-on request
   input  wire        wdog_req,                // watchdog timeout
   input  wire        bus_fault_req,           // double bus fault
   input  wire        clk_loss_det,            // reference lost
   input  wire        clock_loss_reset_enable, // loss reset enable
   input  wire        vco_in_use,              // oscillator in use
   input  wire        test_req,                // test submodule
   input  wire        instr_req,               // reset instruction
   input  wire        bus_busy,                // bus cycle running
   input  wire        bus_cycle_end,           // bus cycle ends
   input  wire [1:0]  bus_monitor_timeout,     // monitor time field
   input  wire [7:0]  mode_pins,               // data bus config pins
   output wire        pin_reset_drive,         // external pin line
   output wire        clock_module_reset,      // clock module line
   output wire        master_reset_line,       // master line
   output wire        instruction_reset_flag,  // instruction flag
   output wire        bus_monitor_force,       // monitor forced on
   output reg         bus_cycle_kill,          // monitor end pulse
   output reg  [7:0]  reset_cause_reg,         // cause bits
   output reg  [7:0]  mode_cfg,                // latched config
   output reg         vector_fetch,            // vector fetch window
   output wire [23:0] vector_base,             // vector table base
   input  wire        cfg_wr_base,             // load boot base
   input  wire        cfg_wr_opt,              // load boot options
   input  wire [15:0] cfg_wdata,               // load data
   input  wire [23:0] addr,                    // bus address
   input  wire        address_strobe,          // address strobe
   input  wire        data_strobe,             // data strobe
   input  wire        rd_wr,                   // 1 read
   input  wire [1:0]  space,                   // access space
   input  wire        eclk,                    // slow bus clock
   input  wire        ext_data_size_acknowledge,               // outside ack
   output wire        boot_select_pin_n,       // boot select, low
   output wire        data_size_acknowledge,   // boot ack pulse
   output wire [15:0] boot_base_q,             // boot base reg
   output wire [15:0] boot_opt_q               // boot option reg
);
   reg  [1:0] state_r;  // sequencer state
   reg  [1:0] state_nxt;
   reg  [7:0] pend_r;   // causes seen this reset
   reg  [7:0] pend_nxt;
   reg        mst_r;    // master line held
   reg        mst_nxt;
   reg        clk_r;    // clock module line held
   reg        clk_nxt;
   reg        ext_r;    // pin line requested
   reg        ext_nxt;
   reg        sysf_r;   // instruction flag held
   reg        sysf_nxt;
   reg        wmst_r;   // sync master waiting
   reg        wmst_nxt;
   reg        wclk_r;   // sync clock line waiting
   reg        wclk_nxt;
   reg        ext_q_r;  // ext_r delayed, for start pulse
   reg  [2:0] ext_cnt_r;// ticks the pin was seen low
   reg  [7:0] bm_cnt_r; // bus monitor ticks
   reg  [7:0] bm_lim;   // bus monitor limit
   reg  [2:0] vec_cnt_r;// vector words fetched
   reg        hand_r;   // master released, fetch next
   wire       tick = system_clock_out;
   wire       tmr_drive;
   wire       tmr_busy;
   wire       tmr_go;
   wire       pin_low;
   wire       ext_req;
   wire       loc_req;
   wire       async_full;
   wire       sync_ok;
   wire       hold;
   wire       boot_rst;
   wire [7:0] new_cause;

   // pin seen low only while we are not driving it
   assign pin_low = !rst_pin_in && rst_pin_oe_n;
   // outside request must last four ticks to count
   assign ext_req = (ext_cnt_r == `RSC_EXT_MIN);
   // clock loss counts only when enabled and on the oscillator
   assign loc_req = clk_loss_det && clock_loss_reset_enable && vco_in_use;
   // catastrophic async sources
   assign async_full = por_req || wdog_req || bus_fault_req;
   // a sync reset may land when no cycle runs or it is ending
   // a kill off a tick waits a round
   assign sync_ok = !bus_busy || bus_cycle_end || bus_cycle_kill;
   // internal request still present keeps the pin driven
   assign hold = async_full || instr_req || loc_req || test_req;

   // every source maps to its cause bit
   assign new_cause = {ext_req, por_req, wdog_req, bus_fault_req, 1'b0,
                       loc_req, instr_req, test_req};

   // async lines bypass the registers so they act at once
   assign master_reset_line  = mst_r || async_full;
   assign clock_module_reset = clk_r || async_full;
   assign pin_reset_drive    = tmr_drive;
   // instruction reset touches only the pin and the flag
   assign instruction_reset_flag = sysf_r || instr_req;
   assign rst_pin_out  = 1'b0;
   assign rst_pin_oe_n = !tmr_drive;
   assign bus_monitor_force = (state_r == `RSC_ST_SYNC);
   assign vector_base = 24'h000000;
   assign tmr_go = ext_r && !ext_q_r;
   // boot select returns to defaults on any master reset
   assign boot_rst = srst || master_reset_line;

   // bus monitor limit from the time field
   always @* begin
      case (bus_monitor_timeout)
         2'd0:    bm_lim = `RSC_BMT_0;
         2'd1:    bm_lim = `RSC_BMT_1;
         2'd2:    bm_lim = `RSC_BMT_2;
         default: bm_lim = `RSC_BMT_3;
      endcase
   end

   // next state: collect causes, union the lines, wait for bus end
   always @* begin
      state_nxt = state_r;
      pend_nxt  = pend_r;
      mst_nxt   = mst_r;
      clk_nxt   = clk_r;
      ext_nxt   = ext_r;
      sysf_nxt  = sysf_r;
      wmst_nxt  = wmst_r;
      wclk_nxt  = wclk_r;
      if (tick && state_r != `RSC_ST_FIN) begin
         pend_nxt = pend_r | new_cause;
         if (async_full) begin
            mst_nxt = 1'b1;
            clk_nxt = 1'b1;
            ext_nxt = 1'b1;
         end
         if (instr_req) begin
            ext_nxt  = 1'b1;
            sysf_nxt = 1'b1;
         end
         // sync sources wait in the monitor-guarded state
         // held lines survive a return to SYNC
         if (ext_req || loc_req || test_req)
            wmst_nxt = 1'b1;
         if (ext_req || loc_req)
            wclk_nxt = 1'b1;
         if (wmst_nxt && sync_ok) begin
            mst_nxt  = 1'b1;
            clk_nxt  = clk_nxt || wclk_nxt;
            ext_nxt  = 1'b1;
            wmst_nxt = 1'b0;
            wclk_nxt = 1'b0;
         end
      end
      case (state_r)
         `RSC_ST_IDLE, `RSC_ST_SYNC: begin
            if (tick) begin
               if (wmst_nxt)
                  state_nxt = `RSC_ST_SYNC;
               else if (ext_nxt)
                  state_nxt = `RSC_ST_ACT;
               else
                  state_nxt = `RSC_ST_IDLE;
            end
         end
         `RSC_ST_ACT: begin
            if (tick && wmst_nxt)
               state_nxt = `RSC_ST_SYNC;
            else if (tick && !tmr_busy && !tmr_go && !hold && !ext_req)
               state_nxt = `RSC_ST_FIN;
         end
         `RSC_ST_FIN: begin
            // release: lines drop, causes move into the cause register
            state_nxt = `RSC_ST_IDLE;
            pend_nxt  = 8'h00;
            mst_nxt   = 1'b0;
            clk_nxt   = 1'b0;
            ext_nxt   = 1'b0;
            sysf_nxt  = 1'b0;
         end
         default: state_nxt = `RSC_ST_IDLE;
      endcase
   end

   // sequencer registers
   always @(posedge sys_clk) begin
      if (srst) begin
         state_r <= `RSC_ST_IDLE;
         pend_r  <= 8'h00;
         mst_r   <= 1'b0;
         clk_r   <= 1'b0;
         ext_r   <= 1'b0;
         sysf_r  <= 1'b0;
         wmst_r  <= 1'b0;
         wclk_r  <= 1'b0;
         ext_q_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pend_r  <= pend_nxt;
         mst_r   <= mst_nxt;
         clk_r   <= clk_nxt;
         ext_r   <= ext_nxt;
         sysf_r  <= sysf_nxt;
         wmst_r  <= wmst_nxt;
         wclk_r  <= wclk_nxt;
         ext_q_r <= ext_r;
      end
   end

   // cause register loads on release, no write path exists
   always @(posedge sys_clk) begin
      if (srst)
         reset_cause_reg <= 8'h00;
      else if (state_r == `RSC_ST_FIN)
         reset_cause_reg <= pend_r;
   end

   // outside low level counted in ticks, saturating at the minimum
   // our own drive never counts as outside
   always @(posedge sys_clk) begin
      if (srst)
         ext_cnt_r <= 3'd0;
      else if (!pin_low)
         ext_cnt_r <= 3'd0;
      else if (tick && ext_cnt_r != `RSC_EXT_MIN)
         ext_cnt_r <= ext_cnt_r + 3'd1;
   end

   // bus monitor: a hung cycle is cut once the timeout elapses
   always @(posedge sys_clk) begin
      if (srst) begin
         bm_cnt_r       <= 8'h00;
         bus_cycle_kill <= 1'b0;
      end else begin
         bus_cycle_kill <= 1'b0;
         if (state_r != `RSC_ST_SYNC || !bus_busy || bus_cycle_end)
            bm_cnt_r <= 8'h00;
         else if (tick) begin
            if (bm_cnt_r == bm_lim - 8'd1) begin
               bus_cycle_kill <= 1'b1;
               bm_cnt_r       <= 8'h00;
            end else
               bm_cnt_r <= bm_cnt_r + 8'd1;
         end
      end
   end

   // mode pins latched when the pin floats high at release of a master reset
   // latched once the pull-ups had time
   always @(posedge sys_clk) begin
      if (srst)
         mode_cfg <= 8'hff;
      else if (state_r == `RSC_ST_FIN && mst_r)
         mode_cfg <= mode_pins;
   end

   // hand-off: after a master reset the processor fetches the vector
   always @(posedge sys_clk) begin
      if (srst) begin
         hand_r       <= 1'b0;
         vector_fetch <= 1'b0;
         vec_cnt_r    <= 3'd0;
      end else begin
         hand_r <= (state_r == `RSC_ST_FIN) && mst_r;
         if (master_reset_line) begin
            vector_fetch <= 1'b0;
            vec_cnt_r    <= 3'd0;
         end else if (hand_r) begin
            vector_fetch <= 1'b1;
            vec_cnt_r    <= 3'd0;
         end else if (vector_fetch && data_size_acknowledge) begin
            if (vec_cnt_r == `RSC_VEC_WORDS - 3'd1)
               vector_fetch <= 1'b0;
            vec_cnt_r <= vec_cnt_r + 3'd1;
         end
      end
   end

   // pin drive and float/retest sequencing
   // timer state alone drives the enable
   rsc_pin_timer u_pin (
      .sys_clk (sys_clk),
      .srst    (srst),
      .tick    (tick),
      .start   (tmr_go),
      .hold    (hold),
      .pin_low (pin_low),
      .drive   (tmr_drive),
      .busy    (tmr_busy)
   );

   // boot memory select
   rsc_boot_select u_boot (
      .sys_clk           (sys_clk),
      .srst              (boot_rst),
      .wr_base           (cfg_wr_base),
      .wr_opt            (cfg_wr_opt),
      .wdata             (cfg_wdata),
      .addr              (addr),
      .address_strobe    (address_strobe),
      .data_strobe       (data_strobe),
      .rd_wr             (rd_wr),
      .space             (space),
      .eclk              (eclk),
      .ext_data_size_acknowledge         (ext_data_size_acknowledge),
      .boot_select_pin_n (boot_select_pin_n),
      .ack               (data_size_acknowledge),
      .base_q            (boot_base_q),
      .opt_q             (boot_opt_q)
   );
endmodule // rsc_reset_ctrl

// ### rsc_regs.vh
// rsc_regs.vh: constants for the reset source controller and boot select
`ifndef RSC_REGS_VH
`define RSC_REGS_VH
// main sequencer states
`define RSC_ST_IDLE       2'd0
`define RSC_ST_SYNC       2'd1
`define RSC_ST_ACT        2'd2
`define RSC_ST_FIN        2'd3
// pin timer states
`define RSC_PT_IDLE       2'd0
`define RSC_PT_DRIVE      2'd1
`define RSC_PT_FLOAT      2'd2
// pin timing in system clock out ticks
`define RSC_PIN_HOLD      10'd512
`define RSC_PIN_FLOAT     10'd10
`define RSC_EXT_MIN       3'd4
// cause bit positions
`define RSC_B_EXT         7
`define RSC_B_POW         6
`define RSC_B_SW          5
`define RSC_B_DBF         4
`define RSC_B_LOC         2
`define RSC_B_SYS         1
`define RSC_B_TST         0
// bus monitor timeouts in ticks, per timeout field code
`define RSC_BMT_0         8'd64
`define RSC_BMT_1         8'd32
`define RSC_BMT_2         8'd16
`define RSC_BMT_3         8'd8
// reset vector fetch: four words
`define RSC_VEC_WORDS     3'd4
// boot select reset values
`define RSC_BASE_RST      16'h0007
`define RSC_OPT_RST       16'h7b70
// option field positions
`define RSC_O_MODE        15
`define RSC_O_BYTE_H      14
`define RSC_O_BYTE_L      13
`define RSC_O_RW_H        12
`define RSC_O_RW_L        11
`define RSC_O_STROBE_SELECT        10
`define RSC_O_ACK_H       9
`define RSC_O_ACK_L       6
`define RSC_O_SPC_H       5
`define RSC_O_SPC_L       4
`define RSC_ACK_FAST      4'he
`define RSC_ACK_EXT       4'hf
`endif

// ### rsc_pin_timer.v
// rsc_pin_timer.v: shared reset pin drive and float/test sequencer
`timescale 1ns/100ps
`include "rsc_regs.vh"
module rsc_pin_timer (
   input  wire       sys_clk, // system clock
   input  wire       srst,    // sync reset
   input  wire       tick,    // system clock out edge
   input  wire       start,   // one-cycle start pulse
   input  wire       hold,    // internal request still present
   input  wire       pin_low, // pin low while not driven by us
   output wire       drive,   // drive pin low
   output wire       busy     // sequence in progress
);
   reg [1:0] state_r; // sequencer state
   reg [9:0] cnt_r;   // tick counter

   assign drive = (state_r == `RSC_PT_DRIVE);
   assign busy  = (state_r != `RSC_PT_IDLE);

   // drive at least 512 ticks, float 10, retest pin and repeat while held low
   always @(posedge sys_clk) begin
      if (srst) begin
         state_r <= `RSC_PT_IDLE;
         cnt_r   <= 10'h000;
      end else begin
         case (state_r)
            `RSC_PT_IDLE: begin
               cnt_r <= 10'h000;
               if (start)
                  state_r <= `RSC_PT_DRIVE;
            end
            `RSC_PT_DRIVE: if (tick) begin
               if (cnt_r == `RSC_PIN_HOLD - 10'd1) begin
                  if (!hold) begin
                     state_r <= `RSC_PT_FLOAT;
                     cnt_r   <= 10'h000;
                  end
               end else
                  cnt_r <= cnt_r + 10'd1;
            end
            `RSC_PT_FLOAT: if (tick) begin
               if (cnt_r == `RSC_PIN_FLOAT - 10'd1) begin
                  cnt_r   <= 10'h000;
                  // an outside device still pulls low: drive again
                  state_r <= pin_low ? `RSC_PT_DRIVE : `RSC_PT_IDLE;
               end else
                  cnt_r <= cnt_r + 10'd1;
            end
            default: state_r <= `RSC_PT_IDLE;
         endcase
      end
   end
endmodule // rsc_pin_timer

// ### rsc_boot_select.v
// rsc_boot_select.v: boot chip select decode and acknowledge timing
`timescale 1ns/100ps
`include "rsc_regs.vh"
module rsc_boot_select (
   input  wire        sys_clk,          // system clock
   input  wire        srst,             // reset incl. master reset
   input  wire        wr_base,          // load base register
   input  wire        wr_opt,           // load option register
   input  wire [15:0] wdata,            // load data
   input  wire [23:0] addr,             // bus address
   input  wire        address_strobe,   // address strobe, high active
   input  wire        data_strobe,      // data strobe, high active
   input  wire        rd_wr,            // 1 read, 0 write
   input  wire [1:0]  space,            // 01 user, 10 supervisor, 00 cpu
   input  wire        eclk,             // slow bus clock phase
   input  wire        ext_data_size_acknowledge,        // outside acknowledge
   output reg         boot_select_pin_n,// boot select, low active
   output reg         ack,              // data_size_acknowledge pulse
   output wire [15:0] base_q,           // base register
   output wire [15:0] opt_q             // option register
);
   reg  [15:0] base_r; // boot_select_base
   reg  [15:0] opt_r;  // boot_select_options
   reg  [3:0]  ws_r;   // wait states elapsed
   reg         done_r; // cycle already acked
   reg  [23:0] mask;   // address bits compared
   wire [3:0]  ackf = opt_r[`RSC_O_ACK_H:`RSC_O_ACK_L];
   wire [1:0]  rwf  = opt_r[`RSC_O_RW_H:`RSC_O_RW_L];
   wire [1:0]  spf  = opt_r[`RSC_O_SPC_H:`RSC_O_SPC_L];
   wire        hit;
   wire        strobe_select;
   wire        ack_now;

   assign base_q = base_r;
   assign opt_q  = opt_r;

   // block size code: 3 gives 128 Kbytes, 7 gives 1 Mbyte
   always @* begin
      case (base_r[2:0])
         3'd0:    mask = 24'hfff800;
         3'd1:    mask = 24'hffe000;
         3'd2:    mask = 24'hffc000;
         3'd3:    mask = 24'hfe0000;
         3'd4:    mask = 24'hfc0000;
         3'd5:    mask = 24'hf80000;
         3'd6:    mask = 24'hf80000;
         default: mask = 24'hf00000;
      endcase
   end

   assign hit = (((addr ^ {base_r[15:3], 11'h000}) & mask) == 24'h000000)
              && (opt_r[`RSC_O_BYTE_H:`RSC_O_BYTE_L] != 2'b00)
              && (rwf == 2'b11 || (rwf == 2'b01 && rd_wr) || (rwf == 2'b10 && !rd_wr))
              && (spf == 2'b11 ? (space == 2'b01 || space == 2'b10) : (space == spf));
   // timing mode 0 emulates async bus, strobe bit picks the strobe
   assign strobe_select = opt_r[`RSC_O_MODE] ? eclk :
                 (opt_r[`RSC_O_STROBE_SELECT] ? data_strobe : address_strobe);
   // internal ack after the programmed count of wait states
   assign ack_now = (ackf == `RSC_ACK_EXT) ? ext_data_size_acknowledge :
                    (ackf == `RSC_ACK_FAST) ? 1'b1 : (ws_r == ackf);

   // option and base registers, reset to the boot defaults
   always @(posedge sys_clk) begin
      if (srst) begin
         base_r <= `RSC_BASE_RST;
         opt_r  <= `RSC_OPT_RST;
      end else begin
         if (wr_base)
            base_r <= wdata;
         if (wr_opt)
            opt_r <= wdata;
      end
   end

   // select pin and one ack per strobed cycle
   always @(posedge sys_clk) begin
      if (srst) begin
         boot_select_pin_n <= 1'b1;
         ack               <= 1'b0;
         ws_r              <= 4'h0;
         done_r            <= 1'b0;
      end else begin
         boot_select_pin_n <= !(hit && strobe_select);
         ack               <= 1'b0;
         if (!(hit && address_strobe)) begin
            ws_r   <= 4'h0;
            done_r <= 1'b0;
         end else if (!done_r) begin
            if (ack_now) begin
               ack    <= 1'b1;
               done_r <= 1'b1;
            end else if (ws_r != 4'hf)
               ws_r <= ws_r + 4'h1;
         end
      end
   end
endmodule // rsc_boot_select

// ### rsc_unused_guard.v
// rsc_unused_guard.v: intentionally empty
`timescale 1ns/100ps

// ### rsc_reset_ctrl_monitor.sv
// rsc_reset_ctrl_monitor.sv: port checker for the reset controller
`timescale 1ns/100ps
module rsc_reset_ctrl_monitor (
   input wire       sys_clk,                // clock
   input wire       srst,                   // reset
   input wire       system_clock_out,       // tick
   input wire       por_req,                // power-on
   input wire       wdog_req,               // watchdog
   input wire       bus_fault_req,          // bus fault
   input wire       instr_req,              // instruction
   input wire       bus_busy,               // bus cycle open
   input wire       rst_pin_oe_n,           // pin enable
   input wire       pin_reset_drive,        // pin line
   input wire       clock_module_reset,     // clock line
   input wire       master_reset_line,      // master line
   input wire       instruction_reset_flag, // flag line
   input wire       bus_monitor_force,      // monitor on
   input wire       bus_cycle_kill,         // monitor end
   input wire [7:0] reset_cause_reg         // cause bits
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic [15:0] drv_cnt_r; // ticks the pin has been driven
   // a drive cut short starves slow devices of reset
   always @(posedge sys_clk) drv_cnt_r <= (srst || !pin_reset_drive) ? 16'h0 : drv_cnt_r + {15'h0, system_clock_out};
   property p_async; (por_req || wdog_req || bus_fault_req) |-> master_reset_line && clock_module_reset; endproperty
   a_async: assert property (p_async) else $error("async lines late");
   property p_clk; clock_module_reset |-> master_reset_line; endproperty
   a_clk: assert property (p_clk) else $error("clock line alone");
   property p_instr; instr_req && system_clock_out |=> instruction_reset_flag; endproperty
   a_instr: assert property (p_instr) else $error("flag missing");
   property p_start; $rose(wdog_req) && system_clock_out &&
      !$past(master_reset_line) |-> ##2 pin_reset_drive; endproperty
   a_start: assert property (p_start) else $error("pin drive late");
   property p_hold; $fell(pin_reset_drive) |-> drv_cnt_r >= 16'd512; endproperty
   a_hold: assert property (p_hold) else $error("pin drive short");
   property p_float; $fell(pin_reset_drive) |-> !pin_reset_drive [*8]; endproperty
   a_float: assert property (p_float) else $error("float cut short");
   property p_cause; $changed(reset_cause_reg) |-> rst_pin_oe_n && !pin_reset_drive; endproperty
   a_cause: assert property (p_cause) else $error("cause loaded early");
   property p_mon; $rose(bus_monitor_force) && bus_busy
      |-> ##[1:200] (bus_cycle_kill || !bus_monitor_force); endproperty
   a_mon: assert property (p_mon) else $error("hung cycle kept");
   property p_kill; bus_cycle_kill |=> !bus_cycle_kill; endproperty
   a_kill: assert property (p_kill) else $error("kill too long");
   cover property (bus_cycle_kill);
   cover property ($changed(reset_cause_reg));
   cover property ($fell(pin_reset_drive));
endmodule // rsc_reset_ctrl_monitor

// ### rsc_pin_dev.sv
// rsc_pin_dev.sv: outside device sharing the pulled-up reset pin
`timescale 1ns/100ps
module rsc_pin_dev #(parameter int LOW_CYCLES = 520) (
   input  wire sys_clk,  // clock
   input  wire req,      // pulse: pull the pin low
   input  wire drv_oe_n, // controller enable, low drives
   input  wire drv_out,  // controller value
   output wire pin       // resolved pin level
);
   int cnt = 0; // cycles left to hold low
   // long enough to overlap an instruction pulse
   always @(posedge sys_clk) cnt <= req ? LOW_CYCLES : (cnt > 0 ? cnt - 1 : 0);
   // pull-up wins when nobody pulls down
   assign pin = (cnt > 0 || (!drv_oe_n && !drv_out)) ? 1'b0 : 1'b1;
endmodule // rsc_pin_dev

// ### rsc_reset_ctrl_tb.sv
// rsc_reset_ctrl_tb.sv: self-checking bench for the reset controller
`timescale 1ns/100ps
module rsc_reset_ctrl_tb;
   logic        sys_clk = 0, srst = 1, system_clock_out = 1, dev_req = 0;
   logic        por_req = 0, wdog_req = 0, bus_fault_req = 0, clk_loss_det = 0, test_req = 0, instr_req = 0;
   logic        clock_loss_reset_enable = 0, vco_in_use = 0, bus_busy = 0, bus_cycle_end = 0, eclk = 0;
   logic        cfg_wr_base = 0, cfg_wr_opt = 0, address_strobe = 0, rd_wr = 1, ext_data_size_acknowledge = 0;
   logic [1:0]  bus_monitor_timeout = 0, space = 2'h2;
   logic [7:0]  mode_pins = 0;
   logic [15:0] cfg_wdata = 0;
   logic [23:0] addr = 0;
   wire         rst_pin_in, rst_pin_out, rst_pin_oe_n, pin_reset_drive, clock_module_reset, master_reset_line;
   wire         instruction_reset_flag, bus_monitor_force, bus_cycle_kill, boot_select_pin_n, data_size_acknowledge;
   wire  [7:0]  reset_cause_reg, mode_cfg;
   wire         vector_fetch;
   wire  [15:0] boot_base_q, boot_opt_q;
   wire         data_strobe = address_strobe;
   int          errors = 0, comparisons = 0, tk, kt, n, n0;
   // per source {master, clock, flag} and cause: wdog, power, fault, clock loss, test, instr, external
   logic [2:0]  exp_lines [7] = '{3'h6, 3'h6, 3'h6, 3'h6, 3'h4, 3'h1, 3'h6};
   logic [7:0]  exp_cause [7] = '{8'h20, 8'h40, 8'h10, 8'h04, 8'h01, 8'h02, 8'h80};
   rsc_reset_ctrl i_rsc_reset_ctrl (.vector_base(), .*);
   rsc_pin_dev i_rsc_pin_dev (.sys_clk(sys_clk), .req(dev_req), .drv_oe_n(rst_pin_oe_n), .drv_out(rst_pin_out),
                              .pin(rst_pin_in));
   initial forever #2.5 sys_clk = ~sys_clk;
   // clock-out ticks come about three cycles in four
   always @(negedge sys_clk) system_clock_out <= ($urandom % 4) != 0;
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tmo(input int c);
      if (c >= 6000) begin
         errors++;
         print_verdict;
      end
   endtask
   task automatic wr(input logic opt, input logic [15:0] d);
      @(negedge sys_clk) {cfg_wr_opt, cfg_wr_base, cfg_wdata} = {opt, !opt, d};
      @(negedge sys_clk) {cfg_wr_opt, cfg_wr_base} = 2'h0;
      chk("boot reg", d, opt ? boot_opt_q : boot_base_q);
   endtask
   // one boot access; d is the acknowledge delay in cycles
   task automatic acc(input logic [23:0] a, input logic rw, input logic sel, output int d);
      @(negedge sys_clk) {addr, rd_wr, address_strobe} = {a, rw, 1'b1};
      @(negedge sys_clk) chk("boot select", !sel, boot_select_pin_n);
      d = 1;
      while (!data_size_acknowledge && d < 30) @(negedge sys_clk) d++;
      chk("ack", sel, data_size_acknowledge);
      @(negedge sys_clk) address_strobe = 0;
      repeat (2) @(negedge sys_clk);
   endtask
   // raise the sources in m, check lines, release, check the recorded cause
   task automatic run(input logic [6:0] m);
      logic [2:0] el;
      logic [7:0] ec;
      el = 0;
      ec = 0;
      for (int i = 0; i < 7; i++) begin
         el |= m[i] ? exp_lines[i] : 3'h0;
         ec |= m[i] ? exp_cause[i] : 8'h0;
      end
      @(negedge sys_clk) {dev_req, instr_req, test_req, clk_loss_det, bus_fault_req, por_req, wdog_req} = m;
      @(negedge sys_clk) dev_req = 0;
      n = 0;
      tk = 0;
      kt = 0;
      while (!pin_reset_drive && n < 6000) begin
         tk += system_clock_out;
         if (bus_cycle_kill && kt == 0) kt = tk;
         @(negedge sys_clk) n++;
      end
      tmo(n);
      chk("lines", el, {master_reset_line, clock_module_reset, instruction_reset_flag});
      {instr_req, test_req, clk_loss_det, bus_fault_req, por_req, wdog_req} = 6'h0;
      n = 0;
      while ((master_reset_line | instruction_reset_flag | pin_reset_drive | !rst_pin_oe_n) && n < 6000)
         @(negedge sys_clk) n++;
      tmo(n);
      @(negedge sys_clk) chk("cause", ec, reset_cause_reg);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      void'($urandom(46));
      mode_pins = $urandom;
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk) srst = 0;
      chk("cause", 16'h0, reset_cause_reg);
      chk("base", 16'h0007, boot_base_q);
      chk("opt", 16'h7b70, boot_opt_q);
      acc(24'h000000, 1, 1, n);
      acc(24'h0ffffe, 1, 1, n);
      acc(24'h100000, 1, 0, n);
      wr(0, 16'h0003);
      acc(24'h01fffe, 1, 1, n);
      acc(24'h020000, 1, 0, n);
      wr(1, 16'h6830);
      acc(24'h000010, 0, 0, n);
      acc(24'h000010, 1, 1, n0);
      wr(1, 16'h68b0);
      acc(24'h000010, 1, 1, n);
      chk("wait states", 16'h2, n - n0);
      for (int i = 0; i < 3; i++) begin
         {vco_in_use, clock_loss_reset_enable, clk_loss_det} = {i[1:0], 1'b1};
         repeat (60) @(negedge sys_clk);
         chk("gated loss", 16'h0, {master_reset_line, pin_reset_drive});
      end
      {vco_in_use, clock_loss_reset_enable, clk_loss_det} = 3'h6;
      for (int i = 0; i < 7; i++) run(7'h1 << i);
      run(7'h31);
      bus_busy = 1;
      bus_monitor_timeout = $urandom;
      run(7'h18);
      chk("kill", 16'h1, kt >= (64 >> bus_monitor_timeout) - 1 && kt <= (64 >> bus_monitor_timeout) + 6);
      chk("mode", mode_pins, mode_cfg);
      chk("fetch", 16'h1, vector_fetch);
      repeat (4) acc(24'h000000, 1, 1, n);
      chk("fetch", 16'h0, vector_fetch);
      print_verdict;
   end
endmodule // rsc_reset_ctrl_tb
bind rsc_reset_ctrl rsc_reset_ctrl_monitor i_rsc_reset_ctrl_monitor (.*);
